// ===== pkg/ims_consts.svh
// constants for the two-wire bus master/slave register block
`ifndef IMS_CONSTS_SVH
`define IMS_CONSTS_SVH
// ==========================================================
// bases and offsets
`define IMS_MASTER_BASE 32'h4002_0000
`define IMS_SLAVE_BASE  32'h4002_0800
`define IMS_OFF_MTA     8'h00
`define IMS_OFF_MCS     8'h04
`define IMS_OFF_MDR     8'h08
`define IMS_OFF_MTPR    8'h0C
`define IMS_OFF_MIMR    8'h10
`define IMS_OFF_MRIS    8'h14
`define IMS_OFF_MMIS    8'h18
`define IMS_OFF_MICR    8'h1C
`define IMS_OFF_MCR     8'h20
`define IMS_OFF_SOAR    8'h00
`define IMS_OFF_SCSR    8'h04
`define IMS_OFF_SDR     8'h08
`define IMS_OFF_SIMR    8'h0C
`define IMS_OFF_SRIS    8'h10
`define IMS_OFF_SMIS    8'h14
`define IMS_OFF_SICR    8'h18
`define IMS_KEY_NONE    9'h1FF
// ==========================================================
// fields and reset values
`define IMS_MCR_MFE     5
`define IMS_MCR_SFE     4
`define IMS_MTPR_RESET  8'h01
// ==========================================================
// scl timing, in divisor units of 2*(divisor+1) clocks
`define IMS_LOW_PH      4'h6
`define IMS_HIGH_PH     4'h4
`define IMS_PH_LAST     4'h9
`define IMS_PH_DRIVE    4'h2
`define IMS_PH_MARK     4'h7
`define IMS_PH_SAMPLE   4'h8
`define IMS_ACK_SLOT    4'h8
`endif

// ===== pkg/ims_pkg.sv
// types shared by the two-wire bus register block
package ims_pkg;
  // ==========================================================
  // engine states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_START = 6'h02,
    ST_ADDR  = 6'h04,
    ST_DATA  = 6'h08,
    ST_STOP  = 6'h10,
    ST_HOLD  = 6'h20
  } ims_state_t;
  // ==========================================================
  // control write and status read layouts
  typedef struct packed {
    logic ack;
    logic stop;
    logic start;
    logic run;
  } ims_cmd_t;
  typedef struct packed {
    logic bus_busy;
    logic idle;
    logic arb_lost;
    logic data_nak;
    logic addr_nak;
    logic error;
    logic busy;
  } ims_status_t;
endpackage

// ===== hdl/ims_regs.sv
// two-wire bus master with register set over apb, slave register set
// Notes on behaviour
// R1 - master registers decode from base 0x40020000, slave registers from 0x40020800
// R2 - scl period is 2*(divisor+1)*(6 low + 4 high) system clocks
// R3 - writing 0x20 to configuration enables master operation
// R4 - target address holds address in bits 7:1, direction in bit 0
// R5 - address byte shifted out equals target address register low byte
// R6 - software loads data before issuing the send command
// R7 - command 0x7 makes start, address byte, one data byte, stop
// R8 - bus busy clears when the transfer ends; software polls it
// R9 - target address bits 31:8 reserved, never changed
// R10 - start bit makes a start, or repeated start when owning the bus
// R11 - stop bit or a nak ends with stop, otherwise bus is held for a burst
// R12 - in receive the ack bit decides whether received bytes are acknowledged
// R13 - control bits: run 0, start 1, stop 2, ack 3
// R14 - raw interrupt status rises when a command completes or aborts
`timescale 1ns/1ps
`include "ims_consts.svh"
module ims_regs
  import ims_pkg::*;
(
  // system
  input  wire logic        CLK,
  input  wire logic        RESET,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // bus lines, open drain
  input  wire logic        LINK_CLK,
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE
);
  // ==========================================================
  // functions
  function automatic logic [8:0] fn_key(input logic [31:0] a);
    fn_key = `IMS_KEY_NONE;
    if (a[31:12] == `IMS_MASTER_BASE >> 12 && a[10:8] == 3'h0)
      fn_key = {a[11], a[7:0]};
  endfunction
  // a change counts once the second and third stages agree
  function automatic logic fn_filt(input logic [2:0] s, input logic f);
    fn_filt = (s[1] == s[2]) ? s[2] : f;
  endfunction

  // ==========================================================
  // declarations
  ims_state_t  st_reg;
  ims_cmd_t    cmd_reg;
  ims_cmd_t    wcmd;
  ims_status_t stat;
  logic [8:0]  key;
  logic        setup_acc;
  logic        wr;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_data;
  logic        rd_hit;
  logic [7:0]  mta_reg;
  logic [7:0]  mdr_reg;
  logic [7:0]  div_reg;
  logic        mimr_reg;
  logic        mris_reg;
  logic [1:0]  mcr_reg;
  logic [6:0]  soar_reg;
  logic [7:0]  sdr_reg;
  logic        simr_reg;
  logic [8:0]  pre_reg;
  logic [3:0]  ph_reg;
  logic [3:0]  bit_reg;
  logic [7:0]  sh_reg;
  logic        adr_nak_reg;
  logic        dat_nak_reg;
  logic        arb_reg;
  logic        done_reg;
  logic        scl_oe_reg;
  logic        sda_oe_reg;
  logic [2:0]  scl_s_reg;
  logic [2:0]  sda_s_reg;
  logic        scl_f_reg;
  logic        sda_f_reg;
  logic [2:0]  bb_s_reg;
  logic        bb_f_reg;
  logic [2:0]  lrst_reg;
  logic        lrst_f_reg;
  logic [2:0]  lscl_s_reg;
  logic [2:0]  lsda_s_reg;
  logic        lscl_f_reg;
  logic        lsda_f_reg;
  logic        lbusy_reg;
  logic [11:0] lc_reg;
  logic        go_cmd;
  logic        active;
  logic        rx;
  logic        stall;
  logic        tick;
  logic        frame_end;
  logic        drive_now;
  logic        mark_now;
  logic        sample_now;
  logic        rx_store;
  logic        nscl;
  logic        nsda;

  // ==========================================================
  // apb slave: two-cycle access phase, answer registered
  assign key       = fn_key(PADDR);
  assign setup_acc = PSEL && PENABLE && !pready_reg;
  assign wr        = PSEL && PENABLE && pready_reg && PWRITE;
  assign wcmd      = ims_cmd_t'(PWDATA[3:0]);
  assign go_cmd    = wr && key == {1'b0, `IMS_OFF_MCS} && mcr_reg[1]; // R3
  assign stat = '{bus_busy: bb_f_reg || st_reg != ST_IDLE, // R8
                  idle:     st_reg == ST_IDLE,
                  arb_lost: arb_reg,
                  data_nak: dat_nak_reg,
                  addr_nak: adr_nak_reg,
                  error:    adr_nak_reg || dat_nak_reg || arb_reg,
                  busy:     st_reg != ST_IDLE && st_reg != ST_HOLD};

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (key) // R1
      {1'b0, `IMS_OFF_MTA}:  rd_data = {24'h000000, mta_reg}; // R9
      {1'b0, `IMS_OFF_MCS}:  rd_data = {25'h0000000, stat};
      {1'b0, `IMS_OFF_MDR}:  rd_data = {24'h000000, mdr_reg};
      {1'b0, `IMS_OFF_MTPR}: rd_data = {24'h000000, div_reg};
      {1'b0, `IMS_OFF_MIMR}: rd_data = {31'h00000000, mimr_reg};
      {1'b0, `IMS_OFF_MRIS}: rd_data = {31'h00000000, mris_reg};
      {1'b0, `IMS_OFF_MMIS}: rd_data = {31'h00000000, mris_reg & mimr_reg};
      {1'b0, `IMS_OFF_MICR}: rd_data = 32'h0000_0000;
      {1'b0, `IMS_OFF_MCR}:  rd_data = {26'h0000000, mcr_reg, 4'h0};
      {1'b1, `IMS_OFF_SOAR}: rd_data = {25'h0000000, soar_reg};
      {1'b1, `IMS_OFF_SCSR}: rd_data = 32'h0000_0000;
      {1'b1, `IMS_OFF_SDR}:  rd_data = {24'h000000, sdr_reg};
      {1'b1, `IMS_OFF_SIMR}: rd_data = {31'h00000000, simr_reg};
      {1'b1, `IMS_OFF_SRIS}: rd_data = 32'h0000_0000;
      {1'b1, `IMS_OFF_SMIS}: rd_data = 32'h0000_0000;
      {1'b1, `IMS_OFF_SICR}: rd_data = 32'h0000_0000;
      default:               rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= setup_acc;
      if (setup_acc)
      begin
        prdata_reg  <= rd_data;
        pslverr_reg <= !rd_hit;
      end
    end
  end

  // ==========================================================
  // software-owned registers; reserved high bits are dropped
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      mta_reg  <= 8'h00;
      div_reg  <= `IMS_MTPR_RESET;
      mimr_reg <= 1'b0;
      mcr_reg  <= 2'h0;
      soar_reg <= 7'h00;
      sdr_reg  <= 8'h00;
      simr_reg <= 1'b0;
    end
    else if (wr)
    begin
      case (key)
        {1'b0, `IMS_OFF_MTA}:  mta_reg  <= PWDATA[7:0]; // R4
        {1'b0, `IMS_OFF_MTPR}: div_reg  <= PWDATA[7:0]; // R2
        {1'b0, `IMS_OFF_MIMR}: mimr_reg <= PWDATA[0];
        {1'b0, `IMS_OFF_MCR}:  mcr_reg  <= {PWDATA[`IMS_MCR_MFE], PWDATA[`IMS_MCR_SFE]}; // R3
        {1'b1, `IMS_OFF_SOAR}: soar_reg <= PWDATA[6:0];
        {1'b1, `IMS_OFF_SDR}:  sdr_reg  <= PWDATA[7:0];
        {1'b1, `IMS_OFF_SIMR}: simr_reg <= PWDATA[0];
        default:               mta_reg  <= mta_reg;
      endcase
    end
  end

  // data register: software load, or the byte just received
  assign rx_store = st_reg == ST_DATA && rx && frame_end && bit_reg == `IMS_ACK_SLOT;
  always_ff @(posedge CLK)
  begin
    if (RESET)
      mdr_reg <= 8'h00;
    else if (rx_store)
      mdr_reg <= sh_reg;
    else if (wr && key == {1'b0, `IMS_OFF_MDR})
      mdr_reg <= PWDATA[7:0];
  end

  // raw status: a completion in the clearing cycle wins
  always_ff @(posedge CLK)
  begin
    if (RESET)
      mris_reg <= 1'b0;
    else if (done_reg)
      mris_reg <= 1'b1; // R14
    else if (wr && key == {1'b0, `IMS_OFF_MICR} && PWDATA[0])
      mris_reg <= 1'b0;
  end

  // ==========================================================
  // pin synchronisers on the system clock
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      bb_s_reg  <= 3'h0;
      bb_f_reg  <= 1'b0;
    end
    else
    begin
      scl_s_reg <= {scl_s_reg[1:0], SCL_I};
      sda_s_reg <= {sda_s_reg[1:0], SDA_I};
      scl_f_reg <= fn_filt(scl_s_reg, scl_f_reg);
      sda_f_reg <= fn_filt(sda_s_reg, sda_f_reg);
      bb_s_reg  <= {bb_s_reg[1:0], lbusy_reg};
      bb_f_reg  <= fn_filt(bb_s_reg, bb_f_reg);
    end
  end

  // ==========================================================
  // bit timing; stretching is only checked at the end of the high
  // phase so the synchroniser lag never lengthens an unstretched clock
  assign active     = st_reg != ST_IDLE && st_reg != ST_HOLD;
  assign rx         = st_reg == ST_DATA && mta_reg[0]; // R4
  assign stall      = ph_reg == `IMS_PH_LAST && !scl_oe_reg && !scl_f_reg;
  assign tick       = pre_reg == {div_reg, 1'b1} && !stall; // R2
  assign frame_end  = tick && ph_reg == `IMS_PH_LAST;
  assign drive_now  = tick && ph_reg == `IMS_PH_DRIVE;
  assign mark_now   = tick && ph_reg == `IMS_PH_MARK;
  assign sample_now = tick && ph_reg == `IMS_PH_SAMPLE;

  always_ff @(posedge CLK)
  begin
    if (RESET || !active)
    begin
      pre_reg <= 9'h000;
      ph_reg  <= 4'h0;
    end
    else if (tick)
    begin
      pre_reg <= 9'h000;
      ph_reg  <= frame_end ? 4'h0 : ph_reg + 4'h1; // R2
    end
    else if (!stall)
      pre_reg <= pre_reg + 9'h001;
  end

  // ==========================================================
  // transfer sequencer
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      st_reg      <= ST_IDLE;
      cmd_reg     <= 4'h0;
      bit_reg     <= 4'h0;
      sh_reg      <= 8'h00;
      adr_nak_reg <= 1'b0;
      dat_nak_reg <= 1'b0;
      arb_reg     <= 1'b0;
      done_reg    <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      unique case (st_reg)
        ST_IDLE, ST_HOLD:
        begin
          if (go_cmd)
          begin
            cmd_reg     <= wcmd; // R13
            adr_nak_reg <= 1'b0;
            dat_nak_reg <= 1'b0;
            arb_reg     <= 1'b0;
            bit_reg     <= 4'h0;
            if (wcmd.run && wcmd.start)
              st_reg <= ST_START; // R10
            else if (st_reg == ST_HOLD && wcmd.run)
            begin
              st_reg <= ST_DATA;
              sh_reg <= mdr_reg;
            end
            else if (st_reg == ST_HOLD && wcmd.stop)
              st_reg <= ST_STOP;
          end
        end
        ST_START:
        begin
          if (frame_end)
          begin
            st_reg <= ST_ADDR;
            sh_reg <= mta_reg; // R5
          end
        end
        ST_ADDR, ST_DATA:
        begin
          if (sample_now && bit_reg == `IMS_ACK_SLOT)
          begin
            if (sda_f_reg && st_reg == ST_ADDR)
              adr_nak_reg <= 1'b1;
            else if (sda_f_reg && !rx)
              dat_nak_reg <= 1'b1;
          end
          else if (sample_now && rx)
            sh_reg <= {sh_reg[6:0], sda_f_reg};
          else if (sample_now && sh_reg[7] && !sda_f_reg)
          begin
            // another master pulled a released one low: back off at once
            arb_reg  <= 1'b1;
            st_reg   <= ST_IDLE;
            done_reg <= 1'b1; // R14
          end
          if (frame_end && bit_reg != `IMS_ACK_SLOT)
          begin
            bit_reg <= bit_reg + 4'h1;
            if (!rx)
              sh_reg <= {sh_reg[6:0], 1'b0};
          end
          else if (frame_end && st_reg == ST_ADDR && !adr_nak_reg)
          begin
            st_reg  <= ST_DATA; // R7
            bit_reg <= 4'h0;
            sh_reg  <= mdr_reg;
          end
          else if (frame_end && (adr_nak_reg || dat_nak_reg || cmd_reg.stop))
            st_reg <= ST_STOP; // R11
          else if (frame_end)
          begin
            st_reg   <= ST_HOLD; // R11
            done_reg <= 1'b1;
          end
        end
        ST_STOP:
        begin
          if (frame_end)
          begin
            st_reg   <= ST_IDLE; // R8
            done_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // line drivers: sda only moves in mid-low, or mid-high for start/stop
  always_ff @(posedge CLK)
  begin
    if (RESET || st_reg == ST_IDLE)
    begin
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      scl_oe_reg <= st_reg == ST_HOLD || ph_reg < `IMS_LOW_PH;
      if (drive_now)
      begin
        if (st_reg == ST_STOP)
          sda_oe_reg <= 1'b1;
        else if (st_reg == ST_START)
          sda_oe_reg <= 1'b0;
        else if (bit_reg == `IMS_ACK_SLOT)
          sda_oe_reg <= rx && cmd_reg.ack; // R12
        else
          sda_oe_reg <= !rx && !sh_reg[7];
      end
      else if (mark_now && st_reg == ST_START)
        sda_oe_reg <= 1'b1; // R10
      else if (mark_now && st_reg == ST_STOP)
        sda_oe_reg <= 1'b0; // R7
    end
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign SCL_OE  = scl_oe_reg;
  assign SDA_OE  = sda_oe_reg;
  assign SCL_O   = 1'b0;
  assign SDA_O   = 1'b0;

  // ==========================================================
  // bus monitor on the link clock: busy from start to stop
  assign nscl = fn_filt(lscl_s_reg, lscl_f_reg);
  assign nsda = fn_filt(lsda_s_reg, lsda_f_reg);
  always_ff @(posedge LINK_CLK)
  begin
    lrst_reg   <= {lrst_reg[1:0], RESET};
    lrst_f_reg <= fn_filt(lrst_reg, lrst_f_reg);
  end

  always_ff @(posedge LINK_CLK)
  begin
    if (lrst_f_reg)
    begin
      lscl_s_reg <= 3'h7;
      lsda_s_reg <= 3'h7;
      lscl_f_reg <= 1'b1;
      lsda_f_reg <= 1'b1;
      lbusy_reg  <= 1'b0;
    end
    else
    begin
      lscl_s_reg <= {lscl_s_reg[1:0], SCL_I};
      lsda_s_reg <= {lsda_s_reg[1:0], SDA_I};
      lscl_f_reg <= nscl;
      lsda_f_reg <= nsda;
      if (lscl_f_reg && nscl && lsda_f_reg && !nsda)
        lbusy_reg <= 1'b1; // R8
      else if (lscl_f_reg && nscl && !lsda_f_reg && nsda)
        lbusy_reg <= 1'b0; // R8
    end
  end

  // ==========================================================
  // checks
  always_ff @(posedge CLK)
  begin
    if (RESET || frame_end || !active)
      lc_reg <= 12'h000;
    else
      lc_reg <= lc_reg + 12'h001;
  end

  sequence s_byte_end;
    st_reg == ST_DATA && frame_end && bit_reg == `IMS_ACK_SLOT;
  endsequence
  sequence s_stop_end;
    st_reg == ST_STOP && frame_end;
  endsequence

  property p_decode;
    @(posedge CLK) disable iff (RESET)
    wr && PADDR == `IMS_MASTER_BASE |=> mta_reg == $past(PWDATA[7:0]);
  endproperty
  a_decode: assert property (p_decode) else $error("target address not written"); // R1
  property p_low_phase;
    @(posedge CLK) disable iff (RESET)
    tick && ph_reg == `IMS_LOW_PH - 4'h1 |->
      int'(lc_reg) == 6 * (2 * int'(div_reg) + 2) - 1;
  endproperty
  a_low_phase: assert property (p_low_phase) else $error("scl low phase length wrong"); // R2
  property p_enable;
    @(posedge CLK) disable iff (RESET)
    wr && key == {1'b0, `IMS_OFF_MCS} && !mcr_reg[1] && st_reg == ST_IDLE |=> st_reg == ST_IDLE;
  endproperty
  a_enable: assert property (p_enable) else $error("ran while master disabled"); // R3
  property p_dir_bit;
    @(posedge CLK) disable iff (RESET)
    st_reg == ST_ADDR && bit_reg == 4'h7 && drive_now |=> sda_oe_reg == !mta_reg[0];
  endproperty
  a_dir_bit: assert property (p_dir_bit) else $error("direction bit wrong"); // R4
  property p_addr_byte;
    @(posedge CLK) disable iff (RESET)
    st_reg == ST_START && frame_end |=> sh_reg == mta_reg && st_reg == ST_ADDR;
  endproperty
  a_addr_byte: assert property (p_addr_byte) else $error("address byte not loaded"); // R5
  property p_stop_after;
    @(posedge CLK) disable iff (RESET)
    s_byte_end ##0 cmd_reg.stop |=> st_reg == ST_STOP;
  endproperty
  a_stop_after: assert property (p_stop_after) else $error("no stop after data byte"); // R7
  property p_done_idle;
    @(posedge CLK) disable iff (RESET)
    s_stop_end |=> !stat.busy ##1 mris_reg;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy after stop"); // R8
  property p_start_cond;
    @(posedge CLK) disable iff (RESET)
    st_reg == ST_START && mark_now |=> sda_oe_reg && !scl_oe_reg;
  endproperty
  a_start_cond: assert property (p_start_cond) else $error("start not on high scl"); // R10
  property p_ack_drive;
    @(posedge CLK) disable iff (RESET)
    rx && bit_reg == `IMS_ACK_SLOT && drive_now |=> sda_oe_reg == cmd_reg.ack;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack level wrong"); // R12
  property p_raw_irq;
    @(posedge CLK) disable iff (RESET)
    done_reg |=> mris_reg;
  endproperty
  a_raw_irq: assert property (p_raw_irq) else $error("raw status not set"); // R14
endmodule // ims_regs

// ===== dv/ims_bus_slave.sv
// two-wire bus target model used by the register block bench
`timescale 1ns/1ps
module ims_bus_slave
  import ims_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = 7'h3B,
  parameter logic [7:0] TX_BYTE  = 8'hA6
)
(
  // bus lines, pulled up outside
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_oe,
  // what the target saw
  output logic [7:0]      rx_addr,
  output logic [7:0]      rx_data,
  output logic            host_ack_low,
  output logic [3:0]      n_start,
  output logic [3:0]      n_stop
);
  // ==========================================================
  // frame tracking
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt;
  logic       first_byte;
  logic       rd_mode;
  initial
  begin
    {sda_oe, rx_addr, rx_data, host_ack_low, n_start, n_stop} = '0;
    {shift_reg, bit_cnt, first_byte, rd_mode} = '0;
  end
  // start and stop are sda edges while scl is high
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      n_start = n_start + 4'h1;
      {bit_cnt, rd_mode, sda_oe} = '0;
      first_byte = 1'b1;
    end
  // the power-up rise of the pulled-up line is not a stop
  always @(posedge sda)
    if (scl === 1'b1 && $time > 0)
    begin
      n_stop = n_stop + 4'h1;
      {bit_cnt, rd_mode, sda_oe, first_byte} = '0;
    end
  // ==========================================================
  // bits are taken on the rising clock edge, msb first
  always @(posedge scl)
    if (bit_cnt < 4'h8)
    begin
      shift_reg = {shift_reg[6:0], sda};
      bit_cnt = bit_cnt + 4'h1;
    end
    else if (bit_cnt == 4'h9 && rd_mode && !first_byte)
    begin
      host_ack_low = !sda;
      rd_mode = !sda;
    end
  // sda drive and captured bytes change on the falling scl edge
  always @(negedge scl)
  begin
    if (bit_cnt == 4'h9)
      {bit_cnt, sda_oe, first_byte} = '0;
    if (bit_cnt == 4'h8)
    begin
      bit_cnt = 4'h9;
      if (first_byte)
      begin
        rx_addr = shift_reg;
        rd_mode = shift_reg[0] && shift_reg[7:1] == OWN_ADDR;
        sda_oe = shift_reg[7:1] == OWN_ADDR;
      end
      else
      begin
        rx_data = rd_mode ? rx_data : shift_reg;
        sda_oe = !rd_mode;
      end
    end
    else if (rd_mode && !first_byte)
      sda_oe = !TX_BYTE[3'h7 - bit_cnt[2:0]];
  end
endmodule // ims_bus_slave

// ===== dv/i2c_master_slave_regs_test.sv
// self-checking bench for the two-wire bus register block
`timescale 1ns/1ps
`include "ims_consts.svh"
module i2c_master_slave_regs_test
  import ims_pkg::*;
;
  // ==========================================================
  // signals
  localparam logic [31:0] MB = `IMS_MASTER_BASE;
  localparam logic [31:0] SB = `IMS_SLAVE_BASE;
  localparam logic [7:0]  M_OFF [7] = '{`IMS_OFF_MTA, `IMS_OFF_MDR, `IMS_OFF_MTPR,
    `IMS_OFF_MIMR, `IMS_OFF_MRIS, `IMS_OFF_MMIS, `IMS_OFF_MCR};
  localparam logic [7:0]  S_OFF [6] = '{`IMS_OFF_SOAR, `IMS_OFF_SCSR, `IMS_OFF_SDR,
    `IMS_OFF_SIMR, `IMS_OFF_SRIS, `IMS_OFF_SMIS};
  logic        CLK, RESET, PSEL, PENABLE, PWRITE, LINK_CLK;
  logic [31:0] PADDR, PWDATA, PRDATA;
  logic        PREADY, PSLVERR, SCL_OE, SDA_OE, slv_oe, host_ack_low;
  logic [7:0]  rx_addr, rx_data;
  logic [3:0]  n_start, n_stop;
  wire         scl_w, sda_w;
  int          err_count, cmp_count;
  realtime     scl_rise, scl_per;
  // pull-ups: a line is low only while some party pulls it
  assign scl_w = !(SCL_OE === 1'b1);
  assign sda_w = !(SDA_OE === 1'b1 || slv_oe === 1'b1);
  ims_regs i_ims_regs (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .LINK_CLK(LINK_CLK), .SCL_I(scl_w), .SCL_O(), .SCL_OE(SCL_OE),
    .SDA_I(sda_w), .SDA_O(), .SDA_OE(SDA_OE));
  ims_bus_slave i_ims_bus_slave (.scl(scl_w), .sda(sda_w), .sda_oe(slv_oe),
    .rx_addr(rx_addr), .rx_data(rx_data), .host_ack_low(host_ack_low),
    .n_start(n_start), .n_stop(n_stop));
  // ==========================================================
  // clocks; link clock offset so its edges drift against CLK
  initial CLK = 1'b0;
  always #20 CLK = ~CLK;
  initial
  begin
    LINK_CLK = 1'b0;
    #1.3;
    forever #3 LINK_CLK = ~LINK_CLK;
  end
  always @(posedge scl_w)
  begin
    scl_per = $realtime - scl_rise;
    scl_rise = $realtime;
  end
  // ==========================================================
  // tasks
  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1)
    begin
      err_count++;
      $display("[FAIL] %0t no bus answer", $time);
      finish_test();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] x, input logic [31:0] m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
  endtask
  // load data, command, then poll one status bit until it clears
  task automatic send(input logic [7:0] d, input logic [31:0] c, input int b);
    logic [31:0] r;
    logic        e;
    int          n;
    wr(MB + `IMS_OFF_MDR, {24'h0, d});
    wr(MB + `IMS_OFF_MCS, c);
    n = 0;
    do
    begin
      apb(1'b0, MB + `IMS_OFF_MCS, 32'h0, r, e);
      n++;
    end
    while (r[b] !== 1'b0 && n < 3000);
    chk({31'h0, r[b]}, 32'h0);
    if (r[b] !== 1'b0)
      finish_test();
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] r;
    logic        e;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 32'h0;
    PWDATA = 32'h0;
    RESET = 1'b1;
    err_count = 0;
    cmp_count = 0;
    scl_rise = 0;
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    foreach (M_OFF[i]) rd_chk(MB + {24'h0, M_OFF[i]}, {31'h0, M_OFF[i] == 8'h0C}, '1);
    foreach (S_OFF[i]) rd_chk(SB + {24'h0, S_OFF[i]}, 32'h0, '1);
    wr(SB + `IMS_OFF_SOAR, 32'h3B);
    rd_chk(SB + `IMS_OFF_SOAR, 32'h3B, 32'h7F);
    rd_chk(MB + `IMS_OFF_MTA, 32'h0, 32'hFF);
    apb(1'b0, MB + 32'h24, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, SB + 32'h1C, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    wr(MB + `IMS_OFF_MRIS, 32'h1);
    rd_chk(MB + `IMS_OFF_MRIS, 32'h0, '1);
    // command before the master is enabled must do nothing
    wr(MB + `IMS_OFF_MTA, 32'h76);
    wr(MB + `IMS_OFF_MTPR, 32'h2);
    wr(MB + `IMS_OFF_MDR, 32'hA5);
    wr(MB + `IMS_OFF_MCS, 32'h7);
    rd_chk(MB + `IMS_OFF_MCS, 32'h0, 32'h41);
    rd_chk(MB + `IMS_OFF_MTA, 32'h76, 32'hFF);
    wr(MB + `IMS_OFF_MCR, 32'h20);
    wr(MB + `IMS_OFF_MIMR, 32'h1);
    send(8'hA5, 32'h7, 6);
    chk({24'h0, rx_addr}, 32'h76);
    chk({24'h0, rx_data}, 32'hA5);
    chk({24'h0, n_start, n_stop}, 32'h11);
    chk($rtoi(scl_per / 40.0), 32'd60);
    rd_chk(MB + `IMS_OFF_MCS, 32'h20, 32'h7F);
    rd_chk(MB + `IMS_OFF_MRIS, 32'h1, 32'h1);
    rd_chk(MB + `IMS_OFF_MMIS, 32'h1, 32'h1);
    wr(MB + `IMS_OFF_MICR, 32'h1);
    rd_chk(MB + `IMS_OFF_MRIS, 32'h0, 32'h1);
    // held bus, repeated start, then continue with stop
    send(8'h3C, 32'h3, 0);
    rd_chk(MB + `IMS_OFF_MCS, 32'h40, 32'h41);
    send(8'h99, 32'h3, 0);
    chk({24'h0, n_start, n_stop}, 32'h31);
    send(8'h5E, 32'h5, 6);
    chk({24'h0, n_start, n_stop}, 32'h32);
    chk({24'h0, rx_data}, 32'h5E);
    // unanswered address at the smallest divisor
    wr(MB + `IMS_OFF_MTPR, 32'h0);
    wr(MB + `IMS_OFF_MTA, 32'h24);
    wr(MB + `IMS_OFF_MICR, 32'h1);
    send(8'h11, 32'h7, 6);
    rd_chk(MB + `IMS_OFF_MCS, 32'h06, 32'h1E);
    rd_chk(MB + `IMS_OFF_MRIS, 32'h1, 32'h1);
    chk($rtoi(scl_per / 40.0), 32'd20);
    chk({24'h0, n_start, n_stop}, 32'h43);
    // receive, with and without acknowledge
    wr(MB + `IMS_OFF_MTA, 32'h77);
    send(8'h00, 32'hF, 6);
    chk({31'h0, host_ack_low}, 32'h1);
    rd_chk(MB + `IMS_OFF_MDR, 32'hA6, 32'hFF);
    send(8'h00, 32'h7, 6);
    chk({31'h0, host_ack_low}, 32'h0);
    finish_test();
  end
endmodule // i2c_master_slave_regs_test
